//--- design/adc_seq_cfg.svh
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH
// ==========================================================
// timing and field constants
`define CONV_CYCLES 4'd11
`define SAMPLE_DLY_CPU 3'd2
`define SAMPLE_DLY_ADC 3'd2
`define TRIG_SYNC_CPU 3'd3
`define PS_W 3
`define SUT_W 6
`define THT_W 2
`define CH_W 6
`define TS_W 3
`define TS_SELF 3'd0
`define ZERO_CNT 10'h000
`define ONE_CNT 10'h001
`define RESULT_RESET 10'h000
`define DIV_RESET 7'h00
`endif

//--- design/adc_seq_pkg.sv
package adc_seq_pkg;
    // ==========================================================
    // sequencer states, one-hot
    typedef enum logic [7:0] {
        ST_OFF = 8'h01,
        ST_SUPPLY = 8'h02,
        ST_STARTUP = 8'h04,
        ST_AMPINIT = 8'h08,
        ST_IDLE = 8'h10,
        ST_DELAY = 8'h20,
        ST_CONV = 8'h40,
        ST_TRACK = 8'h80
    } seq_state_t;
endpackage

//--- design/adc_prescaler.sv
`timescale 1ns/1ns
`include "adc_seq_cfg.svh"
// ==========================================================
// converter clock prescaler: one-cycle tick per converter clock
module adc_prescaler (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic restart,
    input wire logic [`PS_W-1:0] prescale_select_field,
    output logic adc_tick
);
    logic [6:0] div_q;
    logic [6:0] div_d;
    logic [6:0] limit;
    logic tick_d;

    // divide ratio 2^sel, sel 0 treated as 2
    assign limit = (prescale_select_field == 3'h0) ? 7'h01 :
        7'((8'h01 << prescale_select_field) - 8'h01);
    assign tick_d = enable && !restart && (div_q == limit);
    assign div_d = (!enable || restart || tick_d) ? `DIV_RESET :
        7'(div_q + 7'h01);

    // counter held in reset while disabled
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= `DIV_RESET;
            adc_tick <= 1'b0;
        end else begin
            div_q <= div_d;
            adc_tick <= tick_d;
        end
    end
endmodule

//--- design/adc_conversion_sequencer.sv
`timescale 1ns/1ns
`include "adc_seq_cfg.svh"
// Function
// - wait supply ok before powering converter
// - start during startup runs after startup
// - channel follows input until a start request locks it
// - start bit high through single conversion
// - new channel applies after current conversion
// - trigger rising edge in idle restarts prescaler, converts
// - held trigger or busy edge ignored
// - trigger flags set masked; software clears
// - self flag trigger gives free running
// - software start works with auto trigger
// - prescaler divides, reset while disabled
// - startup lasts four times field plus one
// - differential at end of startup adds amplifier init period
// - startup six bits, track two bits
// - timing fields buffered, latched safely
// - fixed start to sample delay
// - idle trigger on single-ended channel adds three cpu cycles
// - eleven cycles, result, flag, clear start unless free running
// - tracking phase after every conversion
// - free running restarts after tracking
// - low byte read blocks result update
// - low channel write loads channel buffer
module adc_conversion_sequencer (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic converter_enable_bit,
    input wire logic start_conversion_write,
    input wire logic auto_trigger_enable,
    input wire logic [`TS_W-1:0] trigger_select_field,
    input wire logic [7:0] trigger_sources,
    input wire logic [`PS_W-1:0] prescale_select_field,
    input wire logic [`SUT_W-1:0] startup_count_field,
    input wire logic [`THT_W-1:0] track_hold_count_field,
    input wire logic timing_config_write,
    input wire logic channel_select_top_bit,
    input wire logic channel_top_write,
    input wire logic [4:0] channel_select_low_bits,
    input wire logic channel_low_write,
    input wire logic channel_differential,
    input wire logic analog_supply_ok_flag,
    input wire logic done_flag_clear,
    input wire logic result_low_read,
    input wire logic result_high_read,
    input wire logic [9:0] core_result,
    output logic analog_supply_rail,
    output logic converter_power,
    output logic amplifier_power,
    output logic sample_hold,
    output logic converting,
    output logic start_conversion_bit,
    output logic conversion_done_flag,
    output logic [`CH_W-1:0] active_channel,
    output logic active_differential,
    output logic [9:0] result
);
    import adc_seq_pkg::*;

    // ==========================================================
    // pin synchronisers
    logic [1:0] sok_s_q;
    logic [7:0] trg_s1_q;
    logic [7:0] trg_s2_q;
    logic sok;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sok_s_q <= 2'b00;
            trg_s1_q <= 8'h00;
            trg_s2_q <= 8'h00;
        end else begin
            sok_s_q <= {sok_s_q[0], analog_supply_ok_flag};
            trg_s1_q <= trigger_sources;
            trg_s2_q <= trg_s1_q;
        end
    end
    assign sok = sok_s_q[1];

    // ==========================================================
    // state and registers
    seq_state_t state_q, state_d;
    logic [9:0] cnt_q, cnt_d;
    logic [2:0] dly_q, dly_d;
    logic pend_q, pend_d;
    logic trg_sel_q, free_q, free_d;
    logic top_tmp_q;
    logic [`CH_W-1:0] ch_tmp_q;
    logic diff_tmp_q;
    logic [`SUT_W-1:0] sut_tmp_q, sut_q;
    logic [`THT_W-1:0] tht_tmp_q, tht_q;
    logic lock_q;
    logic adc_tick;

    // trigger edge detect on selected synced source
    wire trg_sel = trg_s2_q[trigger_select_field];
    wire self_trig = trigger_select_field == `TS_SELF;
    wire trig_edge = auto_trigger_enable && !self_trig && trg_sel
        && !trg_sel_q;
    wire busy = state_q == ST_DELAY || state_q == ST_CONV;
    wire trig_take = trig_edge && !busy;
    wire sw_req = start_conversion_write || pend_q;
    wire tick_last = adc_tick && cnt_q == `ONE_CNT;
    wire diff = active_differential;
    // lengths worked out at full count width so the top field values fit
    wire [9:0] sut_len = {2'b00, sut_q, 2'b00} + 10'h004;
    wire [9:0] ini_len = {7'h00, tht_q, 1'b0} + 10'h006;
    wire [9:0] trk_len = diff ? {7'h00, tht_q, 1'b0} + 10'h003
        : {8'h00, tht_q} + 10'h001;
    wire [2:0] dly_len = trig_take ? 3'(`SAMPLE_DLY_CPU + `TRIG_SYNC_CPU)
        : `SAMPLE_DLY_CPU;
    wire done_evt = state_q == ST_CONV && tick_last;
    wire result_blocked;
    wire ch_open = state_q == ST_OFF || state_q == ST_SUPPLY
        || !lock_q;

    // ==========================================================
    // sequencer next state
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        dly_d = dly_q;
        // a trigger edge during tracking waits for the phase to end
        pend_d = pend_q || start_conversion_write
            || (trig_take && state_q == ST_TRACK);
        free_d = free_q;
        if (adc_tick && cnt_q != `ZERO_CNT)
            cnt_d = 10'(cnt_q - 10'h001);
        unique case (state_q)
            ST_OFF: begin
                state_d = ST_SUPPLY;
            end
            ST_SUPPLY: begin
                if (sok) begin
                    state_d = ST_STARTUP;
                    cnt_d = sut_len;
                end
            end
            ST_STARTUP: begin
                if (tick_last) begin
                    state_d = diff ? ST_AMPINIT : ST_IDLE;
                    cnt_d = ini_len;
                end
            end
            ST_AMPINIT: begin
                if (tick_last)
                    state_d = ST_IDLE;
            end
            ST_IDLE: begin
                if (sw_req || trig_take) begin
                    state_d = ST_DELAY;
                    pend_d = 1'b0;
                    free_d = auto_trigger_enable && self_trig;
                    dly_d = diff ? `SAMPLE_DLY_ADC : dly_len;
                end
            end
            ST_DELAY: begin
                if ((diff ? adc_tick : 1'b1) && dly_q != 3'h0)
                    dly_d = 3'(dly_q - 3'h1);
                if (dly_q == 3'h1 && (diff ? adc_tick : 1'b1)) begin
                    state_d = ST_CONV;
                    cnt_d = 10'(`CONV_CYCLES);
                end
            end
            ST_CONV: begin
                if (tick_last) begin
                    state_d = ST_TRACK;
                    cnt_d = trk_len;
                end
            end
            ST_TRACK: begin
                if (tick_last) begin
                    if (free_q && auto_trigger_enable && self_trig) begin
                        state_d = ST_CONV;
                        cnt_d = 10'(`CONV_CYCLES);
                    end else begin
                        state_d = ST_IDLE;
                        free_d = 1'b0;
                    end
                end
            end
        endcase
        if (!converter_enable_bit) begin
            state_d = ST_OFF;
            cnt_d = `ZERO_CNT;
            pend_d = 1'b0;
            free_d = 1'b0;
        end
    end

    // trigger during busy does not restart prescaler
    adc_prescaler u_prescaler (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .enable(converter_enable_bit),
        .restart(trig_take && state_q == ST_IDLE),
        .prescale_select_field(prescale_select_field),
        .adc_tick(adc_tick)
    );

    // ==========================================================
    // sequencer registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_OFF;
            cnt_q <= `ZERO_CNT;
            dly_q <= 3'h0;
            pend_q <= 1'b0;
            free_q <= 1'b0;
            trg_sel_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            dly_q <= dly_d;
            pend_q <= pend_d;
            free_q <= free_d;
            trg_sel_q <= trg_sel;
        end
    end

    // ==========================================================
    // channel and timing buffers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            top_tmp_q <= 1'b0;
            ch_tmp_q <= 6'h00;
            diff_tmp_q <= 1'b0;
            sut_tmp_q <= 6'h00;
            tht_tmp_q <= 2'h0;
            sut_q <= 6'h00;
            tht_q <= 2'h0;
            active_channel <= 6'h00;
            active_differential <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            if (channel_top_write)
                top_tmp_q <= channel_select_top_bit;
            if (channel_low_write) begin
                ch_tmp_q <= {top_tmp_q, channel_select_low_bits};
                diff_tmp_q <= channel_differential;
            end
            if (timing_config_write) begin
                sut_tmp_q <= startup_count_field;
                tht_tmp_q <= track_hold_count_field;
            end
            // lock from start request until completion
            if (!converter_enable_bit || done_evt)
                lock_q <= 1'b0;
            else if (sok && (start_conversion_write || pend_q
                || state_d == ST_DELAY || state_d == ST_CONV))
                lock_q <= 1'b1;
            if (ch_open) begin
                active_channel <= ch_tmp_q;
                active_differential <= diff_tmp_q;
            end
            if (state_q == ST_OFF || state_q == ST_SUPPLY
                || state_q == ST_IDLE) begin
                sut_q <= sut_tmp_q;
                tht_q <= tht_tmp_q;
            end
        end
    end

    // ==========================================================
    // result, flags and power outputs
    logic blk_q;
    assign result_blocked = blk_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            blk_q <= 1'b0;
            result <= `RESULT_RESET;
            conversion_done_flag <= 1'b0;
            start_conversion_bit <= 1'b0;
            analog_supply_rail <= 1'b0;
            converter_power <= 1'b0;
            amplifier_power <= 1'b0;
            sample_hold <= 1'b0;
            converting <= 1'b0;
        end else begin
            if (result_high_read)
                blk_q <= 1'b0;
            else if (result_low_read)
                blk_q <= 1'b1;
            if (done_evt && !result_blocked)
                result <= core_result;
            // set wins over software clear
            if (done_evt)
                conversion_done_flag <= 1'b1;
            else if (done_flag_clear)
                conversion_done_flag <= 1'b0;
            start_conversion_bit <= converter_enable_bit &&
                (state_d == ST_DELAY || state_d == ST_CONV
                 || pend_d || (free_d && state_d == ST_TRACK));
            analog_supply_rail <= converter_enable_bit;
            converter_power <= converter_enable_bit && state_d != ST_OFF
                && state_d != ST_SUPPLY;
            amplifier_power <= converter_enable_bit && state_d != ST_OFF
                && state_d != ST_SUPPLY && diff_tmp_q;
            sample_hold <= state_d == ST_CONV && state_q != ST_CONV;
            converting <= state_d == ST_CONV;
        end
    end
endmodule

//--- tb/adc_seq_properties.sv
`timescale 1ns/1ns
// ==========================================================
// port properties of the sequencer
module adc_seq_properties (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic converter_enable_bit,
    input wire logic [2:0] prescale_select_field,
    input wire logic analog_supply_rail,
    input wire logic converter_power,
    input wire logic sample_hold,
    input wire logic converting,
    input wire logic start_conversion_bit,
    input wire logic conversion_done_flag,
    input wire logic [5:0] active_channel
);
    logic [9:0] len_q;
    logic [9:0] div_w;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // converter clock period in core cycles
    assign div_w = (prescale_select_field == 3'h0) ? 10'h002 :
        (10'h001 << prescale_select_field);
    // cycles spent in the current conversion
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) len_q <= 10'h000;
        else if (converting) len_q <= len_q + 10'h001;
        else len_q <= 10'h000;
    end
    sequence s_hold;
        sample_hold;
    endsequence
    sequence s_end;
        $fell(converting) && converter_enable_bit
            && $past(converter_enable_bit);
    endsequence
    chk_power_after_supply: assert property (
        converter_power |-> analog_supply_rail)
        else $error("converter powered without supply");
    chk_disable_clears: assert property (
        !converter_enable_bit |=> !converter_power && !converting)
        else $error("disable did not clear sequencer");
    chk_busy_bit_set: assert property (
        converting |-> start_conversion_bit)
        else $error("start bit low during conversion");
    chk_start_clear_done: assert property (
        $fell(start_conversion_bit) && converter_enable_bit
        |-> conversion_done_flag)
        else $error("start bit cleared without done flag");
    chk_hold_pulse: assert property (
        s_hold |=> !sample_hold)
        else $error("sample hold longer than one cycle");
    chk_hold_then_conv: assert property (
        s_hold |-> ##[0:2] converting)
        else $error("no conversion after sample hold");
    chk_no_restart_busy: assert property (
        converting && $past(converting) |-> !sample_hold)
        else $error("new sample during conversion");
    chk_channel_locked: assert property (
        converting && $past(converting) |-> $stable(active_channel))
        else $error("channel changed during conversion");
    chk_conv_length: assert property (
        s_end |-> len_q >= div_w * 10 && len_q <= div_w * 12)
        else $error("conversion length wrong");
endmodule

//--- tb/adc_core_model.sv
`timescale 1ns/1ns
// ==========================================================
// analog core and supply stand-in
module adc_core_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic analog_supply_rail,
    input wire logic converting,
    input wire logic [5:0] active_channel,
    output logic analog_supply_ok_flag,
    output logic [9:0] core_result
);
    logic [3:0] settle_q;
    // supply settles some cycles after the rail is switched on
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) settle_q <= 4'h0;
        else if (!analog_supply_rail) settle_q <= 4'h0;
        else if (settle_q != 4'hf) settle_q <= settle_q + 4'h1;
    end
    assign analog_supply_ok_flag = (settle_q == 4'hf);
    // result valid while converting, toggling garbage otherwise
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) core_result <= 10'h000;
        else if (converting) core_result <= {active_channel, 4'h0} ^ 10'h2a5;
        else core_result <= ~core_result;
    end
endmodule

//--- tb/adc_conversion_sequencer_test.sv
`timescale 1ns/1ns
`include "adc_seq_cfg.svh"
// ==========================================================
// self-checking bench
module adc_conversion_sequencer_test;
    logic core_clk = 0, rst_n = 0, converter_enable_bit = 0;
    logic start_conversion_write = 0, auto_trigger_enable = 0;
    logic timing_config_write = 0, channel_top_write = 0;
    logic channel_low_write = 0, channel_differential = 0;
    logic done_flag_clear = 0, result_low_read = 0, result_high_read = 0;
    logic channel_select_top_bit = 0;
    logic [4:0] channel_select_low_bits = 5'h00;
    logic [2:0] trigger_select_field = 3'h0, prescale_select_field = 3'h0;
    logic [7:0] trigger_sources = 8'h00;
    logic [5:0] startup_count_field = 6'h00, ch, nch;
    logic [1:0] track_hold_count_field = 2'h0;
    logic analog_supply_ok_flag, analog_supply_rail, converter_power;
    logic amplifier_power, sample_hold, converting, start_conversion_bit;
    logic conversion_done_flag, active_differential;
    logic [5:0] active_channel;
    logic [9:0] core_result, result;
    int failures = 0, tests_run = 0, cyc = 0, n;
    adc_conversion_sequencer adc_conversion_sequencer_inst (.core_clk,
        .rst_n, .converter_enable_bit, .start_conversion_write,
        .auto_trigger_enable, .trigger_select_field, .trigger_sources,
        .prescale_select_field, .startup_count_field,
        .track_hold_count_field, .timing_config_write,
        .channel_select_top_bit, .channel_top_write,
        .channel_select_low_bits, .channel_low_write, .channel_differential,
        .analog_supply_ok_flag, .done_flag_clear, .result_low_read,
        .result_high_read, .core_result, .analog_supply_rail,
        .converter_power, .amplifier_power, .sample_hold, .converting,
        .start_conversion_bit, .conversion_done_flag, .active_channel,
        .active_differential, .result);
    adc_core_model adc_core_model_inst (.core_clk, .rst_n,
        .analog_supply_rail, .converting, .active_channel,
        .analog_supply_ok_flag, .core_result);
    // clock and hang guard
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            results();
        end
    end
    function automatic logic [9:0] res_of(input logic [5:0] c);
        return {c, 4'h0} ^ 10'h2a5;
    endfunction
    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        @(posedge core_clk);
        #1 s = 0;
    endtask
    // waits for s high, counting cycles
    task automatic wait_on(ref logic s, output int c);
        for (c = 1; c < 3000; c++) begin
            @(posedge core_clk);
            #1;
            if (s === 1'b1) break;
        end
        check({9'h000, s === 1'b1}, 10'h001);
    endtask
    task automatic set_ch(input logic [5:0] c);
        channel_select_top_bit = c[5];
        pulse(channel_top_write);
        channel_select_low_bits = c[4:0];
        pulse(channel_low_write);
    endtask
    task automatic conv(input logic [5:0] c, input logic [9:0] exp);
        pulse(done_flag_clear);
        set_ch(c);
        pulse(start_conversion_write);
        wait_on(conversion_done_flag, n);
        check(result, exp);
        check({9'h000, start_conversion_bit}, 10'h000);
    endtask
    task automatic results();
        $display("tests %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        n = $urandom(32'hf01f);
        startup_count_field = 6'($urandom_range(0, 3));
        track_hold_count_field = 2'($urandom);
        repeat (5) @(posedge core_clk);
        #1 rst_n = 1;
        pulse(timing_config_write);
        ch = 6'($urandom_range(0, 7));
        set_ch(ch);
        converter_enable_bit = 1;
        pulse(start_conversion_write);
        wait_on(conversion_done_flag, n);
        check({9'h000, n > 8 * (startup_count_field + 1)}, 10'h001);
        check(result, res_of(ch));
        for (int i = 0; i < 4; i++) begin
            ch = 6'($urandom_range(0, 7));
            conv(ch, res_of(ch));
        end
        // channel change in mid conversion
        pulse(done_flag_clear);
        nch = ch ^ 6'h05;
        pulse(start_conversion_write);
        wait_on(converting, n);
        set_ch(nch);
        check({4'h0, active_channel}, {4'h0, ch});
        wait_on(conversion_done_flag, n);
        check(result, res_of(ch));
        repeat (4) @(posedge core_clk);
        #1 check({4'h0, active_channel}, {4'h0, nch});
        // low byte read blocks update until high byte read
        pulse(result_low_read);
        conv(nch, res_of(ch));
        pulse(result_high_read);
        conv(nch, res_of(nch));
        // trigger sources 1 to 7, held level must not retrigger
        auto_trigger_enable = 1;
        for (int ts = 1; ts < 8; ts++) begin
            trigger_select_field = 3'(ts);
            pulse(done_flag_clear);
            trigger_sources[ts] = 1;
            wait_on(conversion_done_flag, n);
            check(result, res_of(nch));
            pulse(done_flag_clear);
            repeat (80) @(posedge core_clk);
            #1 check({9'h000, conversion_done_flag}, 10'h000);
            trigger_sources[ts] = 0;
        end
        // software start from idle: fixed delay to sample and hold
        pulse(start_conversion_write);
        wait_on(sample_hold, n);
        check(10'(n), 10'(`SAMPLE_DLY_CPU));
        wait_on(conversion_done_flag, n);
        conv(ch, res_of(ch));
        // free running off the own done flag
        trigger_select_field = `TS_SELF;
        pulse(start_conversion_write);
        wait_on(sample_hold, n);
        wait_on(sample_hold, n);
        wait_on(sample_hold, n);
        check(10'(n), 10'((track_hold_count_field + 12) * 2));
        converter_enable_bit = 0;
        repeat (2) @(posedge core_clk);
        #1 check({8'h00, converter_power, analog_supply_rail},
            10'h000);
        // prescale changed only while disabled, slower clock
        prescale_select_field = 3'h2;
        auto_trigger_enable = 0;
        converter_enable_bit = 1;
        wait_on(converter_power, n);
        // differential channel picked during start-up
        channel_differential = 1;
        conv(nch, res_of(nch));
        check({8'h00, amplifier_power, active_differential},
            10'h003);
        results();
    end
endmodule
bind adc_conversion_sequencer adc_seq_properties adc_seq_properties_inst (
    .core_clk, .rst_n, .converter_enable_bit, .prescale_select_field,
    .analog_supply_rail, .converter_power, .sample_hold, .converting,
    .start_conversion_bit, .conversion_done_flag, .active_channel);
